// ---- dv/rcs_properties.sv ----
// port assertions for the receive selection block
`timescale 1ns/1ps
module rcs_properties (
	input wire logic        hclk,       // clock
	input wire logic        hresetn,    // reset, low
	input wire logic        hsel,       // select
	input wire logic [1:0]  htrans,     // transfer
	input wire logic        hwrite,     // write
	input wire logic        hready,     // bus ready
	input wire logic [31:0] hrdata,     // read data
	input wire logic        hreadyout,  // slave ready
	input wire logic        hresp,      // response
	input wire logic        rx_ready,   // taken
	input wire logic        out_valid,  // accepted
	input wire logic        out_ready,  // sink ready
	input wire logic [31:0] out_data,   // data
	input wire logic [6:0]  out_channel // channel
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_stall; out_valid && !out_ready; endsequence
	sequence s_empty; !out_valid [*3]; endsequence
	chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	chk_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state seen");
	chk_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved");
	chk_valid_hold: assert property (s_stall |=> out_valid) else $error("element lost in stall");
	chk_data_hold: assert property (s_stall |=> $stable(out_data)) else $error("data moved in stall");
	chk_chan_hold: assert property (s_stall |=> $stable(out_channel)) else $error("channel moved");
	chk_full_fall: assert property ($fell(rx_ready) |-> out_valid) else $error("stall while empty");
	chk_empty_ready: assert property (s_empty |-> rx_ready) else $error("no room while empty");
endmodule // rcs_properties
bind rcs_top rcs_properties chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
	.hresp, .rx_ready, .out_valid, .out_ready, .out_data, .out_channel);

// ---- dv/rcs_top_bench.sv ----
// self-checking bench for the receive selection block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t mismatch %h!=%h", $time, a, b); end end
module rcs_top_bench;
	typedef struct {logic [31:0] c; logic [7:0] a; logic [31:0] e; logic [6:0] ch; logic x;} rcs_row_s;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic        rx_valid, rx_ready, out_valid, out_ready, got, dropped;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  haddr;
	logic [6:0]  rx_channel, out_channel, oc;
	logic [31:0] hwdata, hrdata, rx_data, out_data, od, rd;
	logic [31:0] q [$];
	int          num_errors, checks_done;
	rcs_row_s    rows [12] = '{
		'{32'h000, 8'h10, 32'h0, 7'h7f, 1'b1},
		'{32'h200, 8'h10, 32'h0, 7'h05, 1'b1},
		'{32'h001, 8'h10, 32'h0, 7'h05, 1'b0},
		'{32'h001, 8'h10, 32'h20, 7'h05, 1'b1},
		'{32'h041, 8'h10, 32'h20, 7'h45, 1'b1},
		'{32'h041, 8'h10, 32'h20, 7'h05, 1'b0},
		'{32'h181, 8'h10, 32'h20000, 7'h71, 1'b1},
		'{32'h201, 8'h14, 32'h20000, 7'h31, 1'b1},
		'{32'h201, 8'h18, 32'h1, 7'h40, 1'b1},
		'{32'h201, 8'h1c, 32'h80000000, 7'h7f, 1'b1},
		'{32'h201, 8'h1c, 32'h7fffffff, 7'h7f, 1'b0},
		'{32'h241, 8'h10, 32'h2, 7'h01, 1'b1}
	};
	assign hready = hreadyout;
	rcs_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
		.hresp, .rx_valid, .rx_channel, .rx_data, .rx_ready, .out_valid, .out_ready, .out_data, .out_channel);
	rcs_tx_model tx_u (.hclk, .rx_ready, .rx_valid, .rx_channel, .rx_data);
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	always @(negedge hclk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) q.push_back(out_data);
	end
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic edge_ok;
		bit r;
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			r = hready;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end while (!r && n < 20);
		if (!r) begin
			num_errors++;
			final_report();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= rcs_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		edge_ok();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_ok();
	endtask
	task automatic tx(input logic [6:0] ch, input logic [31:0] d);
		bit ok;
		tx_u.send(ch, d, ok);
		if (!ok) begin
			num_errors++;
			final_report();
		end
	endtask
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata, dropped} = '0;
		hsize = rcs_pkg::HSIZE_WORD;
		out_ready = 1'b1;
		num_errors = 0;
		checks_done = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b1, 8'h20, 32'hffff_ffff);
		for (int a = 16; a <= 32; a += 4) begin
			bus(1'b0, 8'(a), 32'h0);
			`CHK(rd, 32'h0)
		end
		foreach (rows[i]) begin
			bus(1'b1, 8'h00, rows[i].c);
			bus(1'b1, rows[i].a, rows[i].e);
			tx(rows[i].ch, {25'h0, rows[i].ch} ^ 32'h5a00_0000);
			got = 1'b0;
			for (int n = 0; n < 16 && got !== 1'b1; n++) begin
				@(negedge hclk);
				got = out_valid;
				od = out_data;
				oc = out_channel;
			end
			`CHK(got, rows[i].x)
			if (got === 1'b1) `CHK(od, {25'h0, rows[i].ch} ^ 32'h5a00_0000)
			if (got === 1'b1) `CHK(oc, rows[i].ch)
			dropped = dropped | !rows[i].x;
			bus(1'b0, 8'h04, 32'h0);
			`CHK(rd[4:2], rows[i].ch[6:4])
			`CHK(rd[8], dropped)
		end
		bus(1'b1, 8'h00, 32'h0);
		q.delete();
		out_ready <= 1'b0;
		fork
			for (int k = 0; k < 6; k++) tx(7'(k), 32'(k));
			begin
				repeat (40) @(posedge hclk);
				@(negedge hclk);
				`CHK(rx_ready, 1'b0)
				`CHK(q.size(), 0)
				@(posedge hclk);
				out_ready <= 1'b1;
			end
		join
		repeat (20) @(posedge hclk);
		`CHK(q.size(), 6)
		foreach (q[k]) `CHK(q[k], 32'(k))
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'h0)
		final_report();
	end
endmodule // rcs_top_bench

// ---- dv/rcs_tx_model.sv ----
// transmitter model offering one element at a time
`timescale 1ns/1ps
module rcs_tx_model (
	input  wire logic        hclk,       // clock
	input  wire logic        rx_ready,   // taken
	output logic             rx_valid,   // offered
	output logic      [6:0]  rx_channel, // slot
	output logic      [31:0] rx_data     // data
);
	initial begin
		rx_valid = 1'b0;
		rx_channel = 7'h00;
		rx_data = 32'h0000_0000;
	end
	task automatic send(input logic [6:0] ch, input logic [31:0] d, output bit ok);
		bit r;
		int n;
		@(posedge hclk);
		rx_valid <= 1'b1;
		rx_channel <= ch;
		rx_data <= d;
		n = 0;
		do begin
			@(negedge hclk);
			r = rx_ready;
			@(posedge hclk);
			n++;
		end while (!r && n < 200);
		ok = r;
		rx_valid <= 1'b0;
		// released lines show no stale value
		rx_channel <= ~ch;
		rx_data <= ~d;
	endtask
endmodule // rcs_tx_model

// ---- hdl/rcs_fifo.sv ----
// small valid/ready fifo for accepted elements
`timescale 1ns/1ps
module rcs_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,      // clock
	input  wire logic             rst_n,    // async reset, low
	input  wire logic             in_valid, // write request
	output logic                  in_ready, // not full
	input  wire logic [WIDTH-1:0] in_data,  // write data
	output logic                  out_valid,// not empty
	input  wire logic             out_ready,// read request
	output logic      [WIDTH-1:0] out_data  // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             wr, rd;

	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];
	assign wr        = in_valid & in_ready;
	assign rd        = out_valid & out_ready;

	always_comb begin
		wp_d  = wr ? AW'(wp_q + 1'b1) : wp_q;
		rp_d  = rd ? AW'(rp_q + 1'b1) : rp_q;
		cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (wr) begin
			mem_q[wp_q] <= in_data;
		end
	end
endmodule // rcs_fifo

// ---- hdl/rcs_pkg.sv ----
// constants for the receive channel selection block
package rcs_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          FIFO_DEPTH    = 4;
	localparam int          CHAN_W        = 7;
	localparam int          BLK_W         = 3;
	localparam int          PBLK_W        = 2;
	// register byte addresses
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_STATUS    = 8'h04;
	localparam logic [7:0]  OFF_ENABLE0   = 8'h10;
	localparam logic [7:0]  OFF_ENABLE1   = 8'h14;
	localparam logic [7:0]  OFF_ENABLE2   = 8'h18;
	localparam logic [7:0]  OFF_ENABLE3   = 8'h1c;
	// control and status register fields
	localparam int          CTRL_SEL_BIT  = 0;
	localparam int          CTRL_PART_BIT = 9;
	localparam int          CTRL_PA_LSB   = 5;
	localparam int          CTRL_PB_LSB   = 7;
	localparam int          STAT_BLK_LSB  = 2;
	localparam int          STAT_DROP_BIT = 8;
	localparam logic [31:0] ENABLE_RST    = 32'h0000_0000;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage : rcs_pkg

// ---- hdl/rcs_top.sv ----
// receive multichannel selection with ahb-lite registers
// Operation
// - status codes 4-7 mean blocks 4-7
// - selection off accepts all 128 channels
// - selection on accepts only enabled channels
// - partition bit picks two or eight partitions
// - partition bit matters only under selection
// - two partitions use register 0 halves
// - partition blocks from A and B fields
// - eight partitions: register 0 is channels 0-31
// - enhanced mode uses all four registers
// - enable bit 0 disables, 1 enables
// - enable bits matter only under selection
// - three-bit status, codes 0-3 blocks 0-3
// - A field selects even block 0,2,4,6
// - B field selects odd block 1,3,5,7
// - registers 1-3 cover channels 32-127
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module rcs_top (
	input  wire logic        hclk,        // bus clock 50 MHz
	input  wire logic        hresetn,     // async reset, low
	input  wire logic        hsel,        // slave select
	input  wire logic [7:0]  haddr,       // byte address
	input  wire logic [1:0]  htrans,      // transfer type
	input  wire logic        hwrite,      // write
	input  wire logic [2:0]  hsize,       // size
	input  wire logic [31:0] hwdata,      // write data
	input  wire logic        hready,      // bus ready
	output logic      [31:0] hrdata,      // read data
	output logic             hreadyout,   // slave ready
	output logic             hresp,       // always okay
	input  wire logic        rx_valid,    // element received
	input  wire logic [6:0]  rx_channel,  // its channel slot
	input  wire logic [31:0] rx_data,     // element data
	output logic             rx_ready,    // element taken
	output logic             out_valid,   // accepted element
	input  wire logic        out_ready,   // sink ready
	output logic      [31:0] out_data,    // accepted data
	output logic      [6:0]  out_channel  // accepted channel
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic        sel_q, sel_d, part_q, part_d;
	logic [1:0]  pa_q, pa_d, pb_q, pb_d;
	logic [31:0] en_q [4];
	logic [31:0] en_d [4];
	logic [2:0]  blk_q, blk_d;
	logic        drop_q, drop_d;
	logic        wph_q, wph_d;
	logic [7:0]  wad_q, wad_d;
	logic [31:0] rd_q, rd_d;
	logic        ov_q, ov_d, ordy_q, ordy_d;
	logic [31:0] od_q, od_d;
	logic [6:0]  oc_q, oc_d;
	logic        acc;
	logic        f_ready, f_valid, f_take, f_pop;
	logic [2:0]  occ_q, occ_d;
	logic [38:0] f_out;

	// register index of a word address, 4 for none
	function automatic logic [2:0] en_index(input logic [7:0] a);
		case (a)
			rcs_pkg::OFF_ENABLE0: en_index = 3'h0;
			rcs_pkg::OFF_ENABLE1: en_index = 3'h1;
			rcs_pkg::OFF_ENABLE2: en_index = 3'h2;
			rcs_pkg::OFF_ENABLE3: en_index = 3'h3;
			default:              en_index = 3'h4;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// channel acceptance
	// ----------------------------------------------------------------
	function automatic logic chan_ok(input logic [6:0] ch, input logic sel, input logic part,
	                                 input logic [1:0] pa, input logic [1:0] pb,
	                                 input logic [31:0] e0, input logic [31:0] e1,
	                                 input logic [31:0] e2, input logic [31:0] e3);
		logic [2:0]  blk;
		logic [31:0] word;
		blk  = ch[6:4];
		word = e0;
		chan_ok = 1'b0;
		if (!sel) begin
			chan_ok = 1'b1;
		end else if (part) begin
			case (blk[2:1])
				2'h0:    word = e0;
				2'h1:    word = e1;
				2'h2:    word = e2;
				default: word = e3;
			endcase
			chan_ok = word[{blk[0], ch[3:0]}];
		end else if (blk == {pa, 1'b0}) begin
			chan_ok = e0[{1'b0, ch[3:0]}];
		end else if (blk == {pb, 1'b1}) begin
			chan_ok = e0[{1'b1, ch[3:0]}];
		end
	endfunction

	assign acc    = chan_ok(rx_channel, sel_q, part_q, pa_q, pb_q, en_q[0], en_q[1], en_q[2], en_q[3]);
	assign f_take = rx_valid & ordy_q & acc;
	assign f_pop  = f_valid & (!ov_q | out_ready);

	rcs_fifo #(.WIDTH(39), .DEPTH(rcs_pkg::FIFO_DEPTH)) u_fifo (
		.clk       (hclk),
		.rst_n     (hresetn),
		.in_valid  (f_take),
		.in_ready  (f_ready),
		.in_data   ({rx_channel, rx_data}),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_out)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] wi;
		wi     = en_index(wad_q);
		sel_d  = sel_q;
		part_d = part_q;
		pa_d   = pa_q;
		pb_d   = pb_q;
		en_d   = en_q;
		blk_d  = blk_q;
		drop_d = drop_q;
		wph_d  = hsel && hready && htrans == rcs_pkg::HTRANS_NONSEQ && hwrite && hsize == rcs_pkg::HSIZE_WORD;
		wad_d  = hready ? {haddr[7:2], 2'b00} : wad_q;
		rd_d   = rd_q;
		if (wph_q) begin
			if (wad_q == rcs_pkg::OFF_CTRL) begin
				sel_d  = hwdata[rcs_pkg::CTRL_SEL_BIT];
				part_d = hwdata[rcs_pkg::CTRL_PART_BIT];
				pa_d   = hwdata[rcs_pkg::CTRL_PA_LSB +: rcs_pkg::PBLK_W];
				pb_d   = hwdata[rcs_pkg::CTRL_PB_LSB +: rcs_pkg::PBLK_W];
			end else if (!wi[2]) begin
				en_d[wi[1:0]] = hwdata;
			end
		end
		if (rx_valid && ordy_q) begin
			blk_d = rx_channel[6:4];
			if (!acc) begin
				drop_d = 1'b1;
			end
		end
		if (hsel && hready && htrans == rcs_pkg::HTRANS_NONSEQ && !hwrite) begin
			rd_d = '0;
			case ({haddr[7:2], 2'b00})
				rcs_pkg::OFF_CTRL: begin
					rd_d[rcs_pkg::CTRL_SEL_BIT]                       = sel_q;
					rd_d[rcs_pkg::CTRL_PART_BIT]                      = part_q;
					rd_d[rcs_pkg::CTRL_PA_LSB +: rcs_pkg::PBLK_W]     = pa_q;
					rd_d[rcs_pkg::CTRL_PB_LSB +: rcs_pkg::PBLK_W]     = pb_q;
				end
				rcs_pkg::OFF_STATUS: begin
					rd_d[rcs_pkg::STAT_BLK_LSB +: rcs_pkg::BLK_W] = blk_q;
					rd_d[rcs_pkg::STAT_DROP_BIT]                  = drop_q;
				end
				rcs_pkg::OFF_ENABLE0: rd_d = en_q[0];
				rcs_pkg::OFF_ENABLE1: rd_d = en_q[1];
				rcs_pkg::OFF_ENABLE2: rd_d = en_q[2];
				rcs_pkg::OFF_ENABLE3: rd_d = en_q[3];
				default:              rd_d = '0;
			endcase
		end
		// shadow fill count: rx_ready drops in the cycle the fifo fills, not after every take
		occ_d  = 3'(occ_q + {2'b00, f_take} - {2'b00, f_pop});
		ordy_d = f_ready && (occ_d != 3'(rcs_pkg::FIFO_DEPTH));
		ov_d   = ov_q;
		od_d   = od_q;
		oc_d   = oc_q;
		if (!ov_q || out_ready) begin
			ov_d = f_valid;
			if (f_valid) begin
				od_d = f_out[31:0];
				oc_d = f_out[38:32];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q  <= 1'b0;
			part_q <= 1'b0;
			pa_q   <= 2'h0;
			pb_q   <= 2'h0;
			en_q   <= '{default: rcs_pkg::ENABLE_RST};
			blk_q  <= 3'h0;
			drop_q <= 1'b0;
			wph_q  <= 1'b0;
			wad_q  <= 8'h00;
			rd_q   <= 32'h0000_0000;
			ov_q   <= 1'b0;
			od_q   <= 32'h0000_0000;
			oc_q   <= 7'h00;
			ordy_q <= 1'b0;
			occ_q  <= 3'h0;
		end else begin
			sel_q  <= sel_d;
			part_q <= part_d;
			pa_q   <= pa_d;
			pb_q   <= pb_d;
			en_q   <= en_d;
			blk_q  <= blk_d;
			drop_q <= drop_d;
			wph_q  <= wph_d;
			wad_q  <= wad_d;
			rd_q   <= rd_d;
			ov_q   <= ov_d;
			od_q   <= od_d;
			oc_q   <= oc_d;
			ordy_q <= ordy_d;
			occ_q  <= occ_d;
		end
	end

	assign hrdata      = rd_q;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign rx_ready    = ordy_q;
	assign out_valid   = ov_q;
	assign out_data    = od_q;
	assign out_channel = oc_q;
endmodule // rcs_top
